// [rtl/lrc_pkg.sv]
package lrc_pkg;

  localparam int unsigned LRC_ADDR_W = 4;
  localparam logic [LRC_ADDR_W-1:0] LRC_CTRL_OFS    = 4'h0;
  localparam logic [LRC_ADDR_W-1:0] LRC_CMPMODE_OFS = 4'h4;
  localparam logic [LRC_ADDR_W-1:0] LRC_STATUS_OFS  = 4'h8;

  localparam int unsigned LRC_POWER_BIT  = 7;
  localparam int unsigned LRC_ROUTE_BIT  = 6;
  localparam int unsigned LRC_RANGE_BIT  = 5;
  localparam int unsigned LRC_SOURCE_BIT = 4;
  localparam int unsigned LRC_TAP_MSB    = 3;
  localparam int unsigned LRC_TAP_W      = 4;
  localparam int unsigned LRC_CTRL_W     = 8;

  localparam logic [LRC_CTRL_W-1:0] LRC_CTRL_RST    = 8'h00;
  localparam int unsigned           LRC_MODE_W      = 3;
  localparam logic [2:0]            LRC_MODE_RST    = 3'h7;
  localparam logic [2:0]            LRC_MODE_MUX4TO2 = 3'h6;

  localparam int unsigned LRC_LOW_DIV  = 24;
  localparam int unsigned LRC_HIGH_DIV = 32;
  localparam int unsigned LRC_HIGH_BASE = 8;

endpackage

// [rtl/lrc_cfg_if.sv]
`timescale 1ns/1ps
interface lrc_cfg_if;
  import lrc_pkg::*;
  logic [LRC_CTRL_W-1:0] ctrl;
  logic [LRC_MODE_W-1:0] cmp_mode;
  logic                  port_a_direction_pin;
  logic                  ladder_power_on;
  logic                  pin_connect;
  logic                  pin_output_driver_off;
  logic                  comparator_ref_apply;
  logic                  low_range_select;
  logic                  external_source_select;
  logic [LRC_TAP_W-1:0]  ladder_tap_value;
  logic [5:0]            ladder_numerator;
  logic [5:0]            ladder_denominator;

  modport regs (output ctrl, output cmp_mode, output port_a_direction_pin,
                input ladder_power_on, input pin_connect, input pin_output_driver_off,
                input comparator_ref_apply, input low_range_select,
                input external_source_select, input ladder_tap_value,
                input ladder_numerator, input ladder_denominator);
  modport dec  (input ctrl, input cmp_mode, input port_a_direction_pin,
                output ladder_power_on, output pin_connect, output pin_output_driver_off,
                output comparator_ref_apply, output low_range_select,
                output external_source_select, output ladder_tap_value,
                output ladder_numerator, output ladder_denominator);
endinterface

// [rtl/lrc_decode.sv]
`timescale 1ns/1ps
module lrc_decode
  import lrc_pkg::*;
(
  lrc_cfg_if.dec cfg
);

  function automatic logic [5:0] lrc_num(input logic low, input logic [LRC_TAP_W-1:0] tap);
    if (low) begin
      lrc_num = {2'h0, tap};
    end else begin
      lrc_num = 6'(LRC_HIGH_BASE) + {2'h0, tap};
    end
  endfunction

  always_comb begin
    cfg.ladder_power_on        = cfg.ctrl[LRC_POWER_BIT];                     // see (R02)
    cfg.pin_connect            = cfg.ctrl[LRC_ROUTE_BIT];                     // see (R03) (R11)
    cfg.pin_output_driver_off  = cfg.ctrl[LRC_ROUTE_BIT] | cfg.port_a_direction_pin; // see (R04)
    cfg.low_range_select       = cfg.ctrl[LRC_RANGE_BIT];                     // see (R05)
    cfg.external_source_select = cfg.ctrl[LRC_SOURCE_BIT];                    // see (R06)
    cfg.ladder_tap_value       = cfg.ctrl[LRC_TAP_MSB:0];                     // see (R07)
    cfg.ladder_numerator       = lrc_num(cfg.ctrl[LRC_RANGE_BIT], cfg.ctrl[LRC_TAP_MSB:0]);
    cfg.ladder_denominator     = cfg.ctrl[LRC_RANGE_BIT] ? 6'(LRC_LOW_DIV)
                                                         : 6'(LRC_HIGH_DIV); // see (R05)
    cfg.comparator_ref_apply   = (cfg.cmp_mode == LRC_MODE_MUX4TO2);          // see (R12)
  end

endmodule

// [rtl/ladder_reference_control.sv]
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// (R01) An 8-bit read/write control register holds power, pin routing, range, source and tap.
// (R02) The power bit at 1 powers the ladder on and at 0 holds it powered down.
// (R03) The routing bit at 1 connects the reference level to the shared pin, at 0 disconnects it.
// (R04) The routing bit overrides the pin's direction bit so the pin carries the reference.
// (R05) Range at 1 gives tap/24 of the span; range at 0 gives span/4 plus tap/32 of the span.
// (R06) Source at 1 takes the span from the external reference pins, at 0 from the supply rails.
// (R07) The tap field is four bits, 0 to 15, and picks one of sixteen taps in the range.
// (R08) Reset clears power, routing, range and tap, giving a disabled, detached, high-range state.
// (R09) Waking from sleep leaves the control register contents unchanged.
// (R10) Software should clear the power bit before sleep to save current.
// (R11) Enable and routing do not depend on any comparator configuration.
// (R12) The reference goes to both comparators' positive inputs only in the 4-to-2 mux mode.
// (R13) Range, source and tap are static select outputs and power is an active-high enable.
module ladder_reference_control
  import lrc_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [LRC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  port_a_direction,
  input  wire logic                  sleep_wake,
  output logic                       ladder_power_on,
  output logic                       reference_pin_output_enable,
  output logic                       pin_digital_driver_off,
  output logic                       low_range_select,
  output logic                       external_source_select,
  output logic      [LRC_TAP_W-1:0]  ladder_tap_value,
  output logic                       comparator_ref_apply
);

  lrc_cfg_if cfg ();

  logic [LRC_CTRL_W-1:0] ctrl_r;
  logic [LRC_MODE_W-1:0] mode_r;
  logic                  access;
  logic                  wr_en;
  logic                  mapped;

  assign access = psel & penable;
  assign wr_en  = access & pwrite & pstrb[0];
  assign mapped = (paddr == LRC_CTRL_OFS) || (paddr == LRC_CMPMODE_OFS)
                || (paddr == LRC_STATUS_OFS);

  // Sleep wake has no path into this register; only reset and bus writes change it.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= LRC_CTRL_RST;                                    // see (R08)
    end else if (wr_en && paddr == LRC_CTRL_OFS) begin
      ctrl_r <= pwdata[LRC_CTRL_W-1:0];                          // see (R01) (R09)
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r <= LRC_MODE_RST;
    end else if (wr_en && paddr == LRC_CMPMODE_OFS) begin
      mode_r <= pwdata[LRC_MODE_W-1:0];
    end
  end

  assign cfg.ctrl                 = ctrl_r;
  assign cfg.cmp_mode             = mode_r;
  assign cfg.port_a_direction_pin = port_a_direction;

  lrc_decode u_dec (
    .cfg (cfg.dec)
  );

  // Zero-wait slave: pready is high in every access phase.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        LRC_CTRL_OFS:    prdata <= {24'h00_0000, ctrl_r};                 // see (R01)
        LRC_CMPMODE_OFS: prdata <= {29'h0000_0000, mode_r};
        LRC_STATUS_OFS:  prdata <= {30'h0000_0000, comparator_ref_apply,
                                    reference_pin_output_enable};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Outputs are registered copies of the decoded controls, one cycle after the register.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ladder_power_on             <= 1'b0;
      reference_pin_output_enable <= 1'b0;
      pin_digital_driver_off      <= 1'b1;
      low_range_select            <= 1'b0;
      external_source_select      <= 1'b0;
      ladder_tap_value            <= '0;
      comparator_ref_apply        <= 1'b0;
    end else begin
      ladder_power_on             <= cfg.ladder_power_on;        // see (R02) (R13)
      reference_pin_output_enable <= cfg.pin_connect;            // see (R03) (R11)
      pin_digital_driver_off      <= cfg.pin_output_driver_off;  // see (R04)
      low_range_select            <= cfg.low_range_select;       // see (R05) (R13)
      external_source_select      <= cfg.external_source_select; // see (R06) (R13)
      ladder_tap_value            <= cfg.ladder_tap_value;       // see (R07) (R13)
      comparator_ref_apply        <= cfg.comparator_ref_apply;   // see (R12)
    end
  end

endmodule

// [test/lrc_ladder_model.sv]
`timescale 1ns/1ps
module lrc_ladder_model
  import lrc_pkg::*;
(
  input  wire logic                 ladder_power_on,
  input  wire logic                 low_range_select,
  input  wire logic [LRC_TAP_W-1:0] ladder_tap_value,
  output logic      [6:0]           level_96
);
  // The level is counted in 96ths of the span, where tap/24 is 4 steps and tap/32 is 3.
  always_comb begin
    if (!ladder_power_on) begin
      level_96 = 7'h00;
    end else if (low_range_select) begin
      level_96 = 7'(ladder_tap_value * 4);
    end else begin
      level_96 = 7'(LRC_HIGH_BASE * 3 + ladder_tap_value * 3);
    end
  end
endmodule

// [test/lrc_checker_sva.sv]
`timescale 1ns/1ps
module lrc_checker
  import lrc_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [LRC_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready,
  input wire logic                  ladder_power_on,
  input wire logic                  reference_pin_output_enable,
  input wire logic                  pin_digital_driver_off,
  input wire logic                  low_range_select,
  input wire logic                  external_source_select,
  input wire logic                  comparator_ref_apply,
  input wire logic [LRC_TAP_W-1:0]  ladder_tap_value
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic wr   = psel && penable && pwrite && pstrb[0];
  wire logic wr_c = wr && paddr == LRC_CTRL_OFS;
  wire logic wr_m = wr && paddr == LRC_CMPMODE_OFS;
  AST_POWER: assert property (
    wr_c |-> ##2 ladder_power_on == $past(pwdata[7], 2))
    else $error("power bit not applied");
  AST_ROUTE: assert property (
    wr_c |-> ##2 reference_pin_output_enable == $past(pwdata[6], 2))
    else $error("routing bit not applied");
  AST_RANGE: assert property (
    wr_c |-> ##2 low_range_select == $past(pwdata[5], 2))
    else $error("range bit not applied");
  AST_SOURCE: assert property (
    wr_c |-> ##2 external_source_select == $past(pwdata[4], 2))
    else $error("source bit not applied");
  AST_TAP: assert property (
    wr_c |-> ##2 ladder_tap_value == $past(pwdata[3:0], 2))
    else $error("tap value not applied");
  AST_OVERRIDE: assert property (
    reference_pin_output_enable |-> pin_digital_driver_off)
    else $error("pin driver left on while routed");
  AST_RESET: assert property (
    $fell(reset) |-> !ladder_power_on && !low_range_select
      && !reference_pin_output_enable && ladder_tap_value == 4'h0)
    else $error("control not cleared by reset");
  AST_HOLD: assert property (
    !wr_c ##1 !wr_c ##1 !wr_c |=> $stable(ladder_tap_value) && $stable(ladder_power_on))
    else $error("control changed without a write");
  AST_MODE: assert property (
    wr_m |-> ##2 comparator_ref_apply == ($past(pwdata[2:0], 2) == LRC_MODE_MUX4TO2))
    else $error("comparator apply wrong");
  AST_READY: assert property (
    psel && !penable |=> pready)
    else $error("access phase not answered at once");
endmodule
bind ladder_reference_control lrc_checker chk_i (.ref_clk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .ladder_power_on, .reference_pin_output_enable,
  .pin_digital_driver_off, .low_range_select, .external_source_select,
  .comparator_ref_apply, .ladder_tap_value);

// [test/ladder_reference_control_test.sv]
`timescale 1ns/1ps
module ladder_reference_control_test;
  import lrc_pkg::*;
  logic ref_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic port_a_direction = 1'h0, sleep_wake = 1'h0, pready, pslverr, err;
  logic [3:0] paddr = 4'h0, pstrb = 4'hF, ladder_tap_value;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic ladder_power_on, reference_pin_output_enable, pin_digital_driver_off;
  logic low_range_select, external_source_select, comparator_ref_apply;
  logic [6:0] lvl;
  logic [7:0] pattern [7] = '{8'hFF, 8'hA5, 8'h5A, 8'hA0, 8'h80, 8'h9F, 8'h4F};
  int error_cnt = 0, comparisons = 0;
  wire [7:0] outv = {ladder_power_on, reference_pin_output_enable, low_range_select,
                     external_source_select, ladder_tap_value};
  ladder_reference_control dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .port_a_direction, .sleep_wake, .ladder_power_on,
    .reference_pin_output_enable, .pin_digital_driver_off, .low_range_select,
    .external_source_select, .ladder_tap_value, .comparator_ref_apply);
  lrc_ladder_model far (.ladder_power_on, .low_range_select, .ladder_tap_value, .level_96(lvl));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'h1;
    // The wait stays open; only the watchdog may end a transfer that never completes.
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic outs(input logic [7:0] v);
    repeat (2) @(posedge ref_clk);
    apb(1'h0, LRC_CTRL_OFS, 32'h0, 4'hF);
    chk(rd, {24'h0, v});
    chk(outv, v);
  endtask
  task automatic test_reset_values;
    outs(8'h00);
    apb(1'h0, LRC_CMPMODE_OFS, 32'h0, 4'hF);
    chk(rd, {29'h0, LRC_MODE_RST});
    $display("reset value test done");
  endtask
  // Levels are in 96ths of the span: tap/24 is 4 steps, span/4 is 24 and tap/32 is 3.
  task automatic test_fields;
    foreach (pattern[i]) begin
      apb(1'h1, LRC_CTRL_OFS, {24'h0, pattern[i]}, 4'hF);
      outs(pattern[i]);
      chk(lvl, pattern[i][7] ? (pattern[i][5] ? pattern[i][3:0] * 4
                                              : 24 + pattern[i][3:0] * 3) : 0);
    end
    $display("field test done");
  endtask
  task automatic test_pin_and_mode;
    for (int i = 0; i < 4; i++) begin
      port_a_direction <= i[0];
      apb(1'h1, LRC_CTRL_OFS, {25'h0, i[1], 6'h0}, 4'hF);
      outs({1'h0, i[1], 6'h0});
      chk(pin_digital_driver_off, i[1] | i[0]);
      apb(1'h1, LRC_CMPMODE_OFS, 32'(5 + i), 4'hF);
      outs({1'h0, i[1], 6'h0});
      chk(comparator_ref_apply, i == 1);
      apb(1'h0, LRC_STATUS_OFS, 32'h0, 4'hF);
      chk(rd, {30'h0, (i == 1), i[1]});
    end
    $display("pin and mode test done");
  endtask
  task automatic test_refusals;
    apb(1'h1, 4'hC, 32'hFF, 4'hF);
    chk(err, 1'h1);
    apb(1'h0, 4'hC, 32'h0, 4'hF);
    chk(rd, 32'h0);
    chk(err, 1'h1);
    apb(1'h1, LRC_CTRL_OFS, 32'hFF, 4'hE);
    chk(err, 1'h0);
    outs(8'h40);
    $display("refusal test done");
  endtask
  task automatic test_wake;
    apb(1'h1, LRC_CTRL_OFS, 32'h7A, 4'hF);
    sleep_wake <= 1'h1;
    @(posedge ref_clk);
    sleep_wake <= 1'h0;
    outs(8'h7A);
    $display("wake test done");
  endtask
  task automatic test_mid_reset;
    apb(1'h1, LRC_CTRL_OFS, 32'hFF, 4'hF);
    outs(8'hFF);
    reset <= 1'h1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    outs(8'h00);
    apb(1'h0, LRC_CMPMODE_OFS, 32'h0, 4'hF);
    chk(rd, {29'h0, LRC_MODE_RST});
    $display("reset test done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    test_reset_values;
    test_fields;
    test_pin_and_mode;
    test_refusals;
    test_wake;
    test_mid_reset;
    give_verdict;
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
  task automatic give_verdict;
    $display("%0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
endmodule
